//--- inc/alu_ops_regs.vh
`ifndef ALU_OPS_REGS_VH
`define ALU_OPS_REGS_VH
// Operation select codes
`define OP_OR_LITERAL_INTO_ACC 3'h0
`define OP_OR_ACC_WITH_FILE_REG 3'h1
`define OP_LOGICAL_SHIFT_LEFT 3'h2
`define OP_LOGICAL_SHIFT_RIGHT 3'h3
`define OP_MOVE_FILE_REG 3'h4
// Destination select
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
// Reset values
`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0
`define BYTE_ZERO 8'h00
// Bit positions
`define BIT_MSB 7
`define BIT_LSB 0
`endif

//--- logic/logic_shift_move_alu_ops.v
//
// Contract
// (RULE_01) Literal OR merges the accumulator with an 8-bit immediate, writes the accumulator, updates zero.
// (RULE_02) Register OR merges the accumulator with the addressed file register, routes to the destination, updates zero.
// (RULE_03) A destination bit of 0 writes the accumulator, a 1 writes back the addressed file register; literal OR writes the accumulator whatever the bit.
// (RULE_04) Left shift puts source bit 7 into carry, bits 6..0 into result bits 7..1, zero into bit 0, updates carry and zero.
// (RULE_05) Right shift puts source bit 0 into carry, bits 7..1 into result bits 6..0, zero into bit 7, updates carry and zero.
// (RULE_06) Register move copies the addressed file register unchanged to the destination and updates zero.
// (RULE_07) Shifts always insert zero, never the old carry.
// (RULE_08) Zero is set for a zero result and cleared otherwise; flags not named by an operation hold.
//
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_regs.vh"
module logic_shift_move_alu_ops #(
  parameter WIDTH = 8,
  parameter ADDR_W = 7
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Instruction from decoder
  input wire exec_valid,
  input wire [2:0] op_sel,
  input wire [WIDTH-1:0] literal,
  input wire [ADDR_W-1:0] file_addr,
  input wire dest_sel,
  // File register read port
  output wire [ADDR_W-1:0] file_rd_addr,
  input wire [WIDTH-1:0] file_rd_data,
  // File register write port
  output reg file_wr_en,
  output reg [ADDR_W-1:0] file_wr_addr,
  output reg [WIDTH-1:0] file_wr_data,
  // Accumulator and status
  output reg [WIDTH-1:0] acc_q,
  output reg zero_q,
  output reg carry_q
);
  ////////////////////////////////////////////////////////////////////
  wire [WIDTH-1:0] shift_res;
  wire shift_c;
  reg [WIDTH-1:0] res;
  reg known_op;
  reg is_file_op;
  reg carry_upd;
  reg [WIDTH-1:0] acc_d;
  reg zero_d;
  reg carry_d;
  reg wr_en_d;

  assign file_rd_addr = file_addr;

  shift_unit #(
    .WIDTH(WIDTH)
  ) u_shift (
    .src(file_rd_data),
    .shift_right(op_sel == `OP_LOGICAL_SHIFT_RIGHT),
    .result(shift_res),
    .carry_out(shift_c)
  );

  ////////////////////////////////////////////////////////////////////
  always @* begin
    res = `BYTE_ZERO;
    known_op = 1'b1;
    is_file_op = 1'b1;
    carry_upd = 1'b0;
    case (op_sel)
      `OP_OR_LITERAL_INTO_ACC: begin
        res = acc_q | literal; // RULE_01
        is_file_op = 1'b0;
      end
      `OP_OR_ACC_WITH_FILE_REG: begin
        res = acc_q | file_rd_data; // RULE_02
      end
      `OP_LOGICAL_SHIFT_LEFT, `OP_LOGICAL_SHIFT_RIGHT: begin
        res = shift_res; // RULE_04 RULE_05
        carry_upd = 1'b1;
      end
      `OP_MOVE_FILE_REG: begin
        res = file_rd_data; // RULE_06
      end
      default: begin
        known_op = 1'b0;
        is_file_op = 1'b0;
      end
    endcase
  end

  always @* begin
    acc_d = acc_q;
    zero_d = zero_q;
    carry_d = carry_q;
    wr_en_d = 1'b0;
    if (exec_valid && known_op) begin
      zero_d = (res == `BYTE_ZERO); // RULE_08
      if (carry_upd) begin
        carry_d = shift_c; // RULE_04 RULE_05
      end
      if (is_file_op && dest_sel == `DEST_FILE) begin
        wr_en_d = 1'b1; // RULE_03
      end else begin
        acc_d = res; // RULE_03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      acc_q <= `ACC_RESET;
      zero_q <= `FLAG_RESET;
      carry_q <= `FLAG_RESET;
      file_wr_en <= 1'b0;
      file_wr_addr <= {ADDR_W{1'b0}};
      file_wr_data <= `BYTE_ZERO;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      carry_q <= carry_d;
      file_wr_en <= wr_en_d;
      file_wr_addr <= file_addr;
      file_wr_data <= res;
    end
  end
endmodule
`default_nettype wire

//--- logic/shift_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_regs.vh"
module shift_unit #(
  parameter WIDTH = 8
) (
  // Operand and direction
  input wire [WIDTH-1:0] src,
  input wire shift_right,
  // Result
  output reg [WIDTH-1:0] result,
  output reg carry_out
);
  always @* begin
    if (shift_right) begin
      result = {1'b0, src[WIDTH-1:1]}; // RULE_05
      carry_out = src[`BIT_LSB]; // RULE_05
    end else begin
      result = {src[WIDTH-2:0], 1'b0}; // RULE_07
      carry_out = src[WIDTH-1]; // RULE_04
    end
  end
endmodule
`default_nettype wire

//--- test/alu_ops_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module alu_ops_chk(input wire logic clk, reset, exec_valid, dest_sel, file_wr_en, zero_q,
  carry_q, input wire logic [2:0] op_sel,
  input wire logic [7:0] literal, file_rd_data, file_wr_data, acc_q);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire v = exec_valid;
  a_or_lit: assert property (v && op_sel == 0 |=>
    acc_q == ($past(acc_q) | $past(literal))) else $error("lit");
  a_or_reg: assert property (v && op_sel == 1 && dest_sel |=>
    file_wr_data == ($past(acc_q) | $past(file_rd_data))) else $error("orf");
  a_dest_file: assert property (v && op_sel inside {[1:4]} && dest_sel |=>
    file_wr_en && $stable(acc_q)) else $error("dest");
  a_shl_op: assert property (v && op_sel == 2 && !dest_sel |=>
    {carry_q, acc_q} == {$past(file_rd_data), 1'b0}) else $error("shl");
  a_shr_op: assert property (v && op_sel == 3 && !dest_sel |=>
    {acc_q, carry_q} == {1'b0, $past(file_rd_data)}) else $error("shr");
  a_move_op: assert property (v && op_sel == 4 && !dest_sel |=>
    acc_q == $past(file_rd_data)) else $error("mov");
  a_zero_flag: assert property (v && op_sel < 5 |=>
    zero_q == ((file_wr_en ? file_wr_data : acc_q) == 0)) else $error("z");
  a_carry_hold: assert property (v && op_sel inside {0, 1, 4} |=>
    $stable(carry_q)) else $error("c");
endmodule
bind logic_shift_move_alu_ops alu_ops_chk chk_inst(.*);
`default_nettype wire

//--- test/logic_shift_move_alu_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none
module logic_shift_move_alu_ops_tb;
  logic clk = 0, reset = 1, exec_valid = 0, dest_sel = 0, file_wr_en, zero_q, carry_q;
  logic [2:0] op_sel = 0;
  logic [7:0] literal = 0, file_rd_data, file_wr_data, acc_q;
  logic [6:0] file_addr = 0, file_rd_addr, file_wr_addr;
  int err_count = 0, samples_checked = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc > 200) begin err_count++; results; end
  regfile_model regfile_model_inst(.*);
  logic_shift_move_alu_ops logic_shift_move_alu_ops_inst(.*);
  task chk(logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
  endtask
  task op(logic [2:0] o, logic [7:0] k, logic [6:0] a, logic d);
    @(negedge clk);
    {exec_valid, op_sel, literal, file_addr, dest_sel} = {1'b1, o, k, a, d};
    @(negedge clk);
    exec_valid = 0;
  endtask
  task t_or;
    op(0, 8'h5A, 0, 0); chk(acc_q, 8'h5A); chk(zero_q, 0);
    op(1, 0, 7'h21, 1); chk(acc_q, 8'h5A);
    op(4, 0, 7'h21, 0); chk(acc_q, 8'h7B);
  endtask
  task t_shift;
    op(0, 8'h80, 0, 0); op(1, 0, 0, 1);
    op(2, 0, 0, 0); chk(acc_q, 8'hF6); chk(carry_q, 1);
    op(3, 0, 0, 0); chk(acc_q, 8'h7D); chk(carry_q, 1);
    op(3, 0, 1, 0); chk(acc_q, 0); chk(carry_q, 1); chk(zero_q, 1);
  endtask
  task t_dest;
    op(2, 0, 7'h05, 1); chk(file_wr_en, 1); chk(acc_q, 8'h00);
    chk(file_wr_addr, 8'h05); chk(file_wr_data, 8'h0A);
    chk(carry_q, 0); chk(zero_q, 0);
    op(4, 0, 7'h05, 0); chk(acc_q, 8'h0A);
    op(5, 8'hFF, 7'h05, 0); chk(acc_q, 8'h0A); chk(file_wr_en, 0);
    op(0, 8'h01, 7'h05, 1); chk(acc_q, 8'h0B); chk(file_wr_en, 0);
  endtask
  task results;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    reset = 0;
    t_or;
    t_shift;
    t_dest;
    results;
  end
endmodule
`default_nettype wire

//--- test/regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
module regfile_model(input wire logic clk, file_wr_en, input wire logic [6:0] file_rd_addr,
  file_wr_addr, input wire logic [7:0] file_wr_data, output logic [7:0] file_rd_data);
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'(i);
  assign file_rd_data = mem[file_rd_addr];
  always @(posedge clk) if (file_wr_en) mem[file_wr_addr] <= file_wr_data;
endmodule
`default_nettype wire
